// ### src/sar_scan_conversion_timing.v
// scan sequencer with wishbone registers and duration calculation
//
// What this block does
// - coordinate scan lasts settle plus averaged conversions, overheads, plus 15 clocks.
// - n1 is 6 clocks with divider one, else 7 clocks.
// - pressure pair lasts settle plus twice averaged terms plus 22 clocks.
// - single measurement lasts averaged conversions, averages times n1+n2, 17, n3.
// - battery as plain input forces divider 4 and 12-bit resolution.
// - n2 is 24 for temperature, 400 for resistance, 13 otherwise.
// - reference overhead 0 external, 3 fast or always on, else 1+settle.
// - reference settle code sits in bits 3..2 of reference config.
// - with hold field 00 results update without waiting for a read.
// - autoscan cycle sums per-input terms, averaged n2, 9 per input, n3+n4, delay.
// - autoscan converts one to four inputs chosen by enable bits.
// - autoscan adds 11 clocks per average when temperature is selected.
// - delay from bits 2..0, zero while enable bit 3 is clear.
// - port scan lasts three averaged conversion sets plus 35 plus reference.
// - divider in bits 4..3, resolution in bits 6..5 of converter config.
// - average count from bits 1..0, one when averaging disabled.
// - converter clock from oscillator or divided master clock by select bit.
`timescale 1ns/100ps
`include "sar_scan_defines.vh"
module sar_scan_conversion_timing #(
  parameter [15:0] REF_UNIT = 16'h0020,
  parameter [15:0] DEL_UNIT = 16'h0040
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        wbCyc,
  input  wire        wbStb,
  input  wire        wbWe,
  input  wire [7:0]  wbAdr,
  input  wire [3:0]  wbSel,
  input  wire [31:0] wbDatI,
  output reg  [31:0] wbDatO,
  output reg         wbAck,
  input  wire        mclkPin,
  output reg         dataReady,
  output reg         busy
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RUN  = 2'h1;
  localparam [1:0] S_FIN  = 2'h2;

  reg [7:0]  cfgConv_q;
  reg [7:0]  cfgRef_q;
  reg [7:0]  cfgDel_q;
  reg [7:0]  cfgHold_q;
  reg [7:0]  scanSel_q;
  reg [7:0]  cfgClk_q;
  reg [7:0]  settle_q;
  reg [3:0]  cmd_q;
  reg        startReq_q;
  reg [1:0]  state_q;
  reg [15:0] runTotal_q;
  reg [15:0] result_q;
  reg [3:0]  resultCmd_q;
  reg        dataAvail_q;

  reg [15:0] avgN;
  reg [15:0] resN;
  reg [15:0] divN;
  reg [15:0] n1;
  reg [15:0] n2;
  reg [15:0] n2a;
  reg [15:0] n3a;
  reg [15:0] n4;
  reg [15:0] convT;
  reg [15:0] ovhT;
  reg [15:0] refO;
  reg [15:0] inpN;
  reg [15:0] delC;
  reg [15:0] total;
  reg        batAux;

  wire        convTick;
  wire        cntBusy;
  wire        cntDone;
  wire        access   = wbCyc && wbStb && !wbAck;
  wire        wrStb    = access && wbWe && wbSel[0];
  wire        cmdWrite = wrStb && (wbAdr == `OFS_CMD);
  wire        resRead  = access && !wbWe && (wbAdr == `OFS_RESULT);
  wire        holdOff  = (cfgHold_q[`F_HOLD] != 2'b00) && dataAvail_q;
  wire        canStore = (state_q == S_FIN) && !holdOff;
  wire        autoOn   = (cmd_q == `CMD_AUTO);
  wire        startOk  = (state_q == S_IDLE) && startReq_q && !cmdWrite &&
                         (total != `ZERO16);
  wire        loadCnt  = startOk || (canStore && autoOn);

  ////////////////////////////////////////////////////////////////////////
  // code tables
  function [15:0] avgOf;
    input [1:0] code;
    begin
      case (code)
        2'h0:    avgOf = `AVG_0;
        2'h1:    avgOf = `AVG_1;
        2'h2:    avgOf = `AVG_2;
        default: avgOf = `AVG_3;
      endcase
    end
  endfunction

  function [15:0] resOf;
    input [1:0] code;
    begin
      case (code)
        2'h0:    resOf = `RES_0;
        2'h1:    resOf = `RES_1;
        2'h2:    resOf = `RES_2;
        default: resOf = `RES_3;
      endcase
    end
  endfunction

  function [15:0] divOf;
    input [1:0] code;
    begin
      case (code)
        2'h0:    divOf = `DIV_0;
        2'h1:    divOf = `DIV_1;
        2'h2:    divOf = `DIV_2;
        default: divOf = `DIV_3;
      endcase
    end
  endfunction

  // shared by single measurement, autoscan and port scan
  function [15:0] refOvh;
    input        extRef;
    input        refOn;
    input [1:0]  code;
    input [15:0] unit;
    begin
      if (extRef) begin
        refOvh = `ZERO16;
      end else if ((code == 2'b00) || refOn) begin
        refOvh = `REF_FAST;
      end else begin
        refOvh = `REF_BASE + {14'h0000, code} * unit;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // scan duration in converter clock periods
  always @* begin
    batAux = (cmd_q == `CMD_BATT) && !cfgRef_q[`F_BATMODE];
    avgN   = avgOf(cfgConv_q[`F_AVG]);
    resN   = batAux ? `BAT_RES : resOf(cfgConv_q[`F_RES]);
    divN   = batAux ? `BAT_DIV : divOf(cfgConv_q[`F_DIV]);
    n1     = (divN == `DIV_ONE) ? `N1_CONVERSION_CLOCK_DIVIDER : `N1_OTHER;
    convT  = avgN * (resN + `ONE16) * divN;
    ovhT   = avgN * (n1 + `OVH_CONV);
    refO   = refOvh(cfgRef_q[`F_EXTREF], cfgRef_q[`F_REFON],
                    cfgRef_q[`F_REFSET], REF_UNIT);
    inpN   = {15'h0000, scanSel_q[`F_SEL_EXT1]} + {15'h0000, scanSel_q[`F_SEL_EXT2]} +
             {15'h0000, scanSel_q[`F_SEL_BATT]} + {15'h0000, scanSel_q[`F_SEL_TEMP]};
    delC   = cfgDel_q[`F_DELEN] ? {13'h0000, cfgDel_q[`F_DEL]} * DEL_UNIT
                                : `ZERO16;
    n4     = (delC != `ZERO16) ? `N4_DEL : `ZERO16;
    n3a    = (cfgRef_q[`F_EXTREF] || (delC == `ZERO16)) ? `ZERO16 : refO;
    n2a    = scanSel_q[`F_SEL_TEMP] ? `N2_AUTO_TEMP : `ZERO16;
    case (cmd_q)
      `CMD_TEMP: n2 = `N2_TEMP;
      `CMD_EXT1: n2 = scanSel_q[`F_RMODE1] ? `N2_RES : `N2_OTHER;
      `CMD_EXT2: n2 = scanSel_q[`F_RMODE2] ? `N2_RES : `N2_OTHER;
      default:   n2 = `N2_OTHER;
    endcase
    case (cmd_q)
      `CMD_COORD: total = {8'h00, settle_q} + convT + ovhT + `OVH_COORD;
      `CMD_PRESS: total = {8'h00, settle_q} + `PAIR_CNT * (convT + ovhT) +
                          `OVH_PRESS;
      `CMD_TEMP,
      `CMD_EXT1,
      `CMD_EXT2,
      `CMD_BATT:  total = convT + avgN * (n1 + n2) + `OVH_MEAS + refO;
      `CMD_AUTO:  total = (inpN == `ZERO16) ? `ZERO16 :
                          inpN * (convT + ovhT) + avgN * n2a +
                          inpN * `AUTO_PER_INP + n3a + n4 + delC;
      `CMD_PORT:  total = `PORT_CNT * (convT + ovhT) + `OVH_PORT + refO;
      default:    total = `ZERO16;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle
  always @(posedge clk) begin
    if (rst) begin
      wbAck     <= 1'b0;
      wbDatO    <= 32'h0000_0000;
      cfgConv_q <= `RST_CFG;
      cfgRef_q  <= `RST_CFG;
      cfgDel_q  <= `RST_CFG;
      cfgHold_q <= `RST_CFG;
      scanSel_q <= `RST_CFG;
      cfgClk_q  <= `RST_MDIV;
      settle_q  <= `RST_CFG;
    end else begin
      wbAck <= access;
      if (wrStb) begin
        case (wbAdr)
          `OFS_CONV_CFG: cfgConv_q <= wbDatI[7:0];
          `OFS_REF_CFG:  cfgRef_q  <= wbDatI[7:0];
          `OFS_DEL_CFG:  cfgDel_q  <= wbDatI[7:0];
          `OFS_HOLD_CFG: cfgHold_q <= wbDatI[7:0];
          `OFS_SCAN_SEL: scanSel_q <= wbDatI[7:0];
          `OFS_CLK_CFG:  cfgClk_q  <= wbDatI[7:0];
          `OFS_SETTLE:   settle_q  <= wbDatI[7:0];
          default: begin
          end
        endcase
      end
      if (access) begin
        case (wbAdr)
          `OFS_CONV_CFG: wbDatO <= {24'h00_0000, cfgConv_q};
          `OFS_REF_CFG:  wbDatO <= {24'h00_0000, cfgRef_q};
          `OFS_DEL_CFG:  wbDatO <= {24'h00_0000, cfgDel_q};
          `OFS_HOLD_CFG: wbDatO <= {24'h00_0000, cfgHold_q};
          `OFS_SCAN_SEL: wbDatO <= {24'h00_0000, scanSel_q};
          `OFS_CLK_CFG:  wbDatO <= {24'h00_0000, cfgClk_q};
          `OFS_SETTLE:   wbDatO <= {24'h00_0000, settle_q};
          `OFS_CMD:      wbDatO <= {28'h000_0000, cmd_q};
          `OFS_STATUS:   wbDatO <= {24'h00_0000, 1'b0, busy, dataAvail_q, 5'h00};
          `OFS_RESULT:   wbDatO <= {12'h000, resultCmd_q, result_q};
          `OFS_DURATION: wbDatO <= {16'h0000, total};
          default:       wbDatO <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  // any command write aborts the scan in flight; stop just leaves it idle
  always @(posedge clk) begin
    if (rst) begin
      cmd_q       <= `CMD_STOP;
      startReq_q  <= 1'b0;
      state_q     <= S_IDLE;
      runTotal_q  <= `ZERO16;
      result_q    <= `ZERO16;
      resultCmd_q <= `CMD_STOP;
      dataAvail_q <= 1'b0;
      busy        <= 1'b0;
      dataReady   <= 1'b0;
    end else begin
      if (cmdWrite) begin
        cmd_q      <= wbDatI[`F_CMD];
        startReq_q <= (wbDatI[`F_CMD] != `CMD_STOP);
      end else if (state_q == S_IDLE) begin
        startReq_q <= 1'b0;
      end
      if (loadCnt) begin
        runTotal_q <= total;
      end
      // set wins over the clear by a result read
      if (canStore) begin
        result_q    <= runTotal_q;
        resultCmd_q <= cmd_q;
        dataAvail_q <= 1'b1;
      end else if (resRead) begin
        dataAvail_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (startOk) begin
            state_q <= S_RUN;
          end
        end
        S_RUN: begin
          if (cmdWrite) begin
            state_q <= S_IDLE;
          end else if (cntDone) begin
            state_q <= S_FIN;
          end
        end
        S_FIN: begin
          // hold field 00 never waits for the host to read
          if (cmdWrite) begin
            state_q <= S_IDLE;
          end else if (canStore) begin
            state_q <= autoOn ? S_RUN : S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
      // run state covers the gap between the last tick and the store
      busy      <= loadCnt || (cntBusy && !cmdWrite) ||
                   ((state_q == S_RUN) && !cmdWrite) ||
                   ((state_q == S_FIN) && !canStore && !cmdWrite);
      dataReady <= canStore || (dataAvail_q && !resRead);
    end
  end

  conv_clock_gen u_clk (
    .clk     (clk),
    .rst     (rst),
    .useMclk (cfgClk_q[`F_CLKSEL]),
    .mclkDiv (cfgClk_q[`F_MDIV]),
    .mclkPin (mclkPin),
    .tick    (convTick)
  );

  scan_cycle_counter #(
    .W (16)
  ) u_cnt (
    .clk     (clk),
    .rst     (rst),
    .load    (loadCnt),
    .loadVal (total),
    .tick    (convTick),
    .abort   (cmdWrite),
    .busy    (cntBusy),
    .done    (cntDone)
  );
endmodule

// ### src/sar_scan_defines.vh
// constants for the converter scan sequencer
`ifndef SAR_SCAN_DEFINES_VH
`define SAR_SCAN_DEFINES_VH
// register byte offsets
`define OFS_CONV_CFG  8'h00
`define OFS_REF_CFG   8'h04
`define OFS_DEL_CFG   8'h08
`define OFS_HOLD_CFG  8'h0C
`define OFS_SCAN_SEL  8'h10
`define OFS_CLK_CFG   8'h14
`define OFS_CMD       8'h18
`define OFS_STATUS    8'h1C
`define OFS_RESULT    8'h20
`define OFS_SETTLE    8'h24
`define OFS_DURATION  8'h28
`define RST_CFG       8'h00
`define RST_MDIV      8'h01
// field positions
`define F_AVG     1:0
`define F_DIV     4:3
`define F_RES     6:5
`define F_BATMODE 0
`define F_REFSET  3:2
`define F_EXTREF  4
`define F_REFON   5
`define F_DEL     2:0
`define F_DELEN   3
`define F_HOLD    6:5
`define F_SEL     3:0
`define F_SEL_EXT1 0
`define F_SEL_EXT2 1
`define F_SEL_BATT 2
`define F_SEL_TEMP 3
`define F_RMODE1  4
`define F_RMODE2  5
`define F_CLKSEL  7
`define F_MDIV    6:0
`define F_CMD     3:0
`define ST_BUSY   6
`define ST_AVAIL  5
// commands
`define CMD_STOP  4'h0
`define CMD_COORD 4'h1
`define CMD_PRESS 4'h2
`define CMD_TEMP  4'h3
`define CMD_EXT1  4'h4
`define CMD_EXT2  4'h5
`define CMD_BATT  4'h6
`define CMD_AUTO  4'h7
`define CMD_PORT  4'h8
// timing terms, in converter clock periods
`define OVH_COORD    16'h000F
`define OVH_PRESS    16'h0016
`define OVH_MEAS     16'h0011
`define OVH_PORT     16'h0023
`define OVH_CONV     16'h000D
`define AUTO_PER_INP 16'h0009
`define N1_CONVERSION_CLOCK_DIVIDER      16'h0006
`define N1_OTHER     16'h0007
`define N2_TEMP      16'h0018
`define N2_RES       16'h0190
`define N2_OTHER     16'h000D
`define N2_AUTO_TEMP 16'h000B
`define N4_DEL       16'h0007
`define REF_FAST     16'h0003
`define REF_BASE     16'h0001
`define BAT_DIV      16'h0004
`define BAT_RES      16'h000C
`define PAIR_CNT     16'h0002
`define PORT_CNT     16'h0003
`define DIV_ONE      16'h0001
`define ONE16        16'h0001
`define ZERO16       16'h0000
// code tables for averaging, resolution and divider
`define AVG_0 16'h0001
`define AVG_1 16'h0004
`define AVG_2 16'h0008
`define AVG_3 16'h0010
`define RES_0 16'h000A
`define RES_1 16'h0008
`define RES_2 16'h000C
`define RES_3 16'h000C
`define DIV_0 16'h0001
`define DIV_1 16'h0002
`define DIV_2 16'h0004
`define DIV_3 16'h0008
`define OSC_PERIOD_NS 122
`define CLK_PERIOD_NS 20
`endif

// ### src/conv_clock_gen.v
// converter clock tick from the oscillator or the divided master clock
`timescale 1ns/100ps
`include "sar_scan_defines.vh"
module conv_clock_gen #(
  parameter integer OSC_CYCLES = `OSC_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       useMclk,
  input  wire [6:0] mclkDiv,
  input  wire       mclkPin,
  output reg        tick
);
  localparam integer OSC_LAST_I = OSC_CYCLES - 1;
  localparam [7:0]   OSC_LAST   = OSC_LAST_I[7:0];
  reg [7:0] oscCnt_q;
  reg       mSync1_q;
  reg       mSync2_q;
  reg       mSync3_q;
  reg [6:0] mCnt_q;
  wire       mEdge   = mSync2_q & ~mSync3_q;
  wire [6:0] mdivEff = (mclkDiv == 7'h00) ? 7'h01 : mclkDiv;
  wire       mTerm   = mEdge && (mCnt_q == mdivEff - 7'h01);
  wire       oscTerm = (oscCnt_q == OSC_LAST);
  always @(posedge clk) begin
    if (rst) begin
      oscCnt_q <= 8'h00;
      mSync1_q <= 1'b0;
      mSync2_q <= 1'b0;
      mSync3_q <= 1'b0;
      mCnt_q   <= 7'h00;
      tick     <= 1'b0;
    end else begin
      mSync1_q <= mclkPin;
      mSync2_q <= mSync1_q;
      mSync3_q <= mSync2_q;
      oscCnt_q <= oscTerm ? 8'h00 : oscCnt_q + 8'h01;
      if (mEdge) begin
        mCnt_q <= mTerm ? 7'h00 : mCnt_q + 7'h01;
      end
      tick <= useMclk ? mTerm : oscTerm;
    end
  end
endmodule

// ### src/scan_cycle_counter.v
// down counter of converter clock periods for one scan
`timescale 1ns/100ps
module scan_cycle_counter #(
  parameter integer W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         load,
  input  wire [W-1:0] loadVal,
  input  wire         tick,
  input  wire         abort,
  output reg          busy,
  output reg          done
);
  reg [W-1:0] count_q;
  always @(posedge clk) begin
    if (rst) begin
      count_q <= {W{1'b0}};
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (load) begin
        count_q <= loadVal;
        busy    <= 1'b1;
      end else if (busy && tick) begin
        if (count_q <= {{(W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ### test/scan_mclk_source.sv
// master clock source on the board side of the sequencer
`timescale 1ns/100ps
module scan_mclk_source #(
  parameter real HALF_NS = 23.0
) (
  output reg mclkPin
);
  // free running, phase unrelated to clk
  initial mclkPin = 1'b0;
  always #(HALF_NS) mclkPin = ~mclkPin;
endmodule

// ### test/scan_timing_sva.sv
// port assertions for the scan sequencer
`timescale 1ns/100ps
`include "sar_scan_defines.vh"
module scan_timing_sva #(
  parameter [15:0] REF_UNIT = 16'h0020,
  parameter [15:0] DEL_UNIT = 16'h0040
) (
  input wire        clk,
  input wire        rst,
  input wire        wbCyc,
  input wire        wbStb,
  input wire        wbWe,
  input wire [7:0]  wbAdr,
  input wire [3:0]  wbSel,
  input wire [31:0] wbDatI,
  input wire [31:0] wbDatO,
  input wire        wbAck,
  input wire        mclkPin,
  input wire        dataReady,
  input wire        busy
);
  wire taken = wbCyc && wbStb && !wbAck;
  wire cmdWr = taken && wbWe && wbSel[0] && (wbAdr == `OFS_CMD);
  wire resRd = taken && !wbWe && (wbAdr == `OFS_RESULT);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ackPulse;
    wbAck ##1 !wbAck;
  endsequence
  sequence s_quietStart;
    $rose(busy) ##1 (!cmdWr)[*6];
  endsequence
  a_ack_follows: assert property (taken |=> s_ackPulse)
    else $error("ack not a single pulse after request");
  a_no_stray_ack: assert property (!(wbCyc && wbStb) |=> !wbAck)
    else $error("ack without request");
  a_upper_zero: assert property (wbAck |-> wbDatO[31:20] == 12'h000)
    else $error("read data upper bits set");
  a_unmapped_read: assert property ((taken && !wbWe && wbAdr > `OFS_DURATION) |=> wbDatO == 0)
    else $error("unmapped read not zero");
  a_cmd_starts: assert property ((cmdWr && wbDatI[3:0] == `CMD_COORD) |-> ##[2:4] busy)
    else $error("coordinate scan did not start");
  a_stop_idles: assert property ((cmdWr && wbDatI[3:0] == `CMD_STOP) |-> ##[1:4] !busy)
    else $error("stop left sequencer busy");
  a_ready_until_read: assert property ($fell(dataReady) |-> $past(resRd, 1) || $past(resRd, 2))
    else $error("data flag dropped without result read");
  a_store_after_busy: assert property ($rose(dataReady) |-> $past(busy, 1) || $past(busy, 2))
    else $error("data flag without a scan");
  a_busy_holds: assert property (s_quietStart |-> busy)
    else $error("scan ended too early");
endmodule

// ### test/tb_top.sv
// testbench for the scan sequencer
`timescale 1ns/100ps
`include "sar_scan_defines.vh"
module tb_top;
  localparam [15:0] REFU = 16'h0002;
  localparam [15:0] DELU = 16'h0003;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         wbCyc = 1'b0;
  reg         wbStb = 1'b0;
  reg         wbWe = 1'b0;
  reg  [7:0]  wbAdr = 8'h00;
  reg  [3:0]  wbSel = 4'h0;
  reg  [31:0] wbDatI = 32'h0000_0000;
  wire [31:0] wbDatO;
  wire        wbAck;
  wire        mclkPin;
  wire        dataReady;
  wire        busy;
  integer     failures = 0;
  integer     checksDone = 0;
  integer     i, c, n, d, f;
  reg  [31:0] rd;
  reg  [39:0] sets [0:3];
  always #10 clk = ~clk;
  scan_mclk_source mclk_u (.mclkPin(mclkPin));
  sar_scan_conversion_timing #(.REF_UNIT(REFU), .DEL_UNIT(DELU)) dut_u (
    .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .mclkPin(mclkPin),
    .dataReady(dataReady), .busy(busy));
  ////////////////////////////////////////
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task checkVal(input [31:0] got, input [31:0] exp);
    begin
      checksDone = checksDone + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task checkFlag(input got, input exp);
    begin
      checkVal({31'h0000_0000, got}, {31'h0000_0000, exp});
    end
  endtask
  task xfer(input [7:0] a, input we, input [7:0] dat, input [3:0] sel);
    integer k;
    begin
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= sel;
      wbDatI <= {24'h00_0000, dat};
      k = 0;
      @(posedge clk);
      while (wbAck !== 1'b1 && k < 40) begin
        k = k + 1;
        @(posedge clk);
      end
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      if (k >= 40) begin
        failures = failures + 1;
        $display("[ERR] %0t bus answer timed out", $time);
        stop_test;
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] dat);
    xfer(a, 1'b1, dat, 4'h1);
  endtask
  task rdChk(input [7:0] a, input [31:0] exp);
    begin
      xfer(a, 1'b0, 8'h00, 4'h1);
      checkVal(rd, exp);
    end
  endtask
  task waitReady;
    begin
      n = 0;
      while (dataReady !== 1'b1 && n < 20000) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= 20000) begin
        failures = failures + 1;
        $display("[ERR] %0t scan result timed out", $time);
        stop_test;
      end
    end
  endtask
  // fields: conv, ref, delay, select, settle
  task applySet(input [39:0] s);
    begin
      wr(`OFS_CONV_CFG, s[39:32]);
      wr(`OFS_REF_CFG, s[31:24]);
      wr(`OFS_DEL_CFG, s[23:16]);
      wr(`OFS_SCAN_SEL, s[15:8]);
      wr(`OFS_SETTLE, s[7:0]);
    end
  endtask
  function integer expDur(input [3:0] cmd, input [39:0] s);
    integer avg, res, dv, n1, n2, n3, cnv, del, ni;
    begin
      avg = (s[33:32] == 2'd0) ? 1 : (4 << (s[33:32] - 2'd1));
      res = s[38] ? 12 : (s[37] ? 8 : 10);
      dv = 1 << s[36:35];
      if (cmd == `CMD_BATT && !s[24]) begin
        dv = 4;
        res = 12;
      end
      n1 = (dv == 1) ? 6 : 7;
      n3 = s[28] ? 0 : ((s[27:26] == 2'd0 || s[29]) ? 3 : 1 + s[27:26] * REFU);
      cnv = avg * ((res + 1) * dv + n1 + 13);
      n2 = (cmd == `CMD_TEMP) ? 24 : (((cmd == `CMD_EXT1 && s[12]) ||
           (cmd == `CMD_EXT2 && s[13])) ? 400 : 13);
      del = s[19] ? s[18:16] * DELU : 0;
      ni = s[8] + s[9] + s[10] + s[11];
      case (cmd)
        `CMD_COORD: expDur = s[7:0] + cnv + 15;
        `CMD_PRESS: expDur = s[7:0] + 2 * cnv + 22;
        `CMD_AUTO:  expDur = ni * cnv + avg * (s[11] ? 11 : 0) + ni * 9 + (del ? n3 + 7 : 0) + del;
        `CMD_PORT:  expDur = 3 * cnv + 35 + n3;
        default:    expDur = avg * ((res + 1) * dv + n1 + n2) + 17 + n3;
      endcase
    end
  endfunction
  task autoRun(input [7:0] hold, input expStall);
    begin
      wr(`OFS_HOLD_CFG, hold);
      wr(`OFS_CMD, `CMD_AUTO);
      waitReady;
      f = 0;
      repeat (4) @(posedge clk);
      for (n = 0; n < d * 12 + 60; n = n + 1) begin
        @(posedge clk);
        if (busy === 1'b0) f = 1;
      end
      checkFlag(f[0], 1'b0);
      rdChk(`OFS_RESULT, {12'h000, `CMD_AUTO, d[15:0]});
      // a held result lands right after the read, a free run stores much later
      repeat (3) @(posedge clk);
      checkFlag(dataReady, expStall);
      wr(`OFS_CMD, `CMD_STOP);
      xfer(`OFS_RESULT, 1'b0, 8'h00, 4'h1);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    // battery joins autoscan whenever its select bit is set, battery mode is not checked
    sets[0] = 40'h00_1000_0100;
    sets[1] = 40'h29_000F_0805;
    sets[2] = 40'h52_0D07_1FFF;
    sets[3] = 40'h7B_2509_2610;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdChk(`OFS_CLK_CFG, 32'h0000_0001);
    rdChk(`OFS_CONV_CFG, 32'h0000_0000);
    wr(8'h2C, 8'hFF);
    rdChk(8'h2C, 32'h0000_0000);
    xfer(`OFS_CONV_CFG, 1'b1, 8'h7B, 4'h0);
    rdChk(`OFS_CONV_CFG, 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1) begin
      applySet(sets[i]);
      for (c = 1; c < 9; c = c + 1) begin
        wr(`OFS_CMD, c[7:0]);
        d = expDur(c[3:0], sets[i]);
        rdChk(`OFS_DURATION, {16'h0000, d[15:0]});
      end
      wr(`OFS_CMD, `CMD_STOP);
    end
    applySet(sets[0]);
    d = expDur(`CMD_EXT1, sets[0]);
    wr(`OFS_CMD, `CMD_EXT1);
    rdChk(`OFS_STATUS, 32'h0000_0040);
    waitReady;
    // oscillator tick is every 6 clocks
    checkFlag(n >= d * 6 - 12 && n <= d * 6 + 12, 1'b1);
    rdChk(`OFS_STATUS, 32'h0000_0020);
    rdChk(`OFS_RESULT, {12'h000, `CMD_EXT1, d[15:0]});
    rdChk(`OFS_STATUS, 32'h0000_0000);
    wr(`OFS_CLK_CFG, 8'h82);
    d = expDur(`CMD_COORD, sets[0]);
    wr(`OFS_CMD, `CMD_COORD);
    waitReady;
    rdChk(`OFS_RESULT, {12'h000, `CMD_COORD, d[15:0]});
    wr(`OFS_CLK_CFG, 8'h01);
    wr(`OFS_SCAN_SEL, 8'h00);
    wr(`OFS_CMD, `CMD_AUTO);
    repeat (4) @(posedge clk);
    checkFlag(busy, 1'b0);
    wr(`OFS_SCAN_SEL, 8'h01);
    d = expDur(`CMD_AUTO, sets[0]);
    autoRun(8'h00, 1'b0);
    autoRun(8'h20, 1'b1);
    stop_test;
  end
endmodule

bind sar_scan_conversion_timing scan_timing_sva #(
  .REF_UNIT(REF_UNIT),
  .DEL_UNIT(DEL_UNIT)
) chk_u (
  .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
  .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .mclkPin(mclkPin),
  .dataReady(dataReady), .busy(busy));
